// ---- hdl/meas_ctrl_pkg.sv ----
// Purpose: shared constants, states and checksum for the measurement block
// Assumes: 100 MHz block clock
// Notes: timing counts are derived from the printed times

package meas_ctrl_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int UPDATE_TIME_NS = 500000;
  localparam int TRIG_TIME_NS = 45000000;
  localparam int AVG_WIN_NS = 25000000;
  localparam int STOP_TIME_NS = 500000;
  localparam int UPDATE_CYC = UPDATE_TIME_NS / CLK_PERIOD_NS;
  localparam int TRIG_CYC = TRIG_TIME_NS / CLK_PERIOD_NS;
  localparam int AVG_WIN_CYC = AVG_WIN_NS / CLK_PERIOD_NS;
  localparam int STOP_CYC = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 23;

  localparam logic [6:0] ADDR_GND = 7'h21;
  localparam logic [6:0] ADDR_R1K2 = 7'h22;
  localparam logic [6:0] ADDR_R2K7 = 7'h23;
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_R1K2 = 2'h1;
  localparam logic [1:0] STRAP_R2K7 = 2'h2;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  localparam logic [15:0] CMD_CONT_MF_AVG = 16'h3603;
  localparam logic [15:0] CMD_CONT_MF = 16'h3608;
  localparam logic [15:0] CMD_CONT_DP_AVG = 16'h3615;
  localparam logic [15:0] CMD_CONT_DP = 16'h361E;
  localparam logic [15:0] CMD_STOP = 16'h3FF9;
  localparam logic [15:0] CMD_TRIG_MF = 16'h3624;
  localparam logic [15:0] CMD_TRIG_MF_STR = 16'h3726;
  localparam logic [15:0] CMD_TRIG_DP = 16'h362F;
  localparam logic [15:0] CMD_TRIG_DP_STR = 16'h372D;

  // smoothing factor 0.05 in Q16
  localparam logic [15:0] ALPHA_Q16 = 16'h0CCD;
  localparam logic [15:0] SCALE_FACTOR = 16'h003C;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;

  localparam logic [1:0] WORD_PRESS = 2'h0;
  localparam logic [1:0] WORD_TEMP = 2'h1;
  localparam logic [1:0] WORD_SCALE = 2'h2;
  localparam int WORD_W = 25;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CONT = 4'h2,
    ST_TRIG = 4'h4,
    ST_STOP = 4'h8
  } mode_state_e;

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

endpackage

// ---- hdl/pair_buf.sv ----
// Purpose: two-entry buffer between result sequencer and link front end
// Assumes: single clock, flush drops everything held
// Notes: full and empty are exact, so a stalled reader stops the writer

`timescale 1ns/1ns
module pair_buf #(
  parameter int W = 25
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);

  logic [W-1:0] slot0, slot1, next_slot0, next_slot1;
  logic [1:0] cnt, next_cnt;
  logic rd, next_rd, wr, next_wr;
  logic push, pop;

  assign in_ready_o = (cnt != 2'h2);
  assign out_valid_o = (cnt != 2'h0);
  assign out_data_o = rd ? slot1 : slot0;

  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_slot0 = slot0;
    next_slot1 = slot1;
    next_rd = rd;
    next_wr = wr;
    next_cnt = cnt;
    if (push) begin
      if (wr) begin
        next_slot1 = in_data_i;
      end else begin
        next_slot0 = in_data_i;
      end
      next_wr = !wr;
    end
    if (pop) begin
      next_rd = !rd;
    end
    if (push && !pop) begin
      next_cnt = cnt + 2'h1;
    end else if (pop && !push) begin
      next_cnt = cnt - 2'h1;
    end
    if (flush_i) begin
      next_rd = 1'b0;
      next_wr = 1'b0;
      next_cnt = 2'h0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot0 <= '0;
      slot1 <= '0;
      rd <= 1'b0;
      wr <= 1'b0;
      cnt <= 2'h0;
    end else begin
      slot0 <= next_slot0;
      slot1 <= next_slot1;
      rd <= next_rd;
      wr <= next_wr;
      cnt <= next_cnt;
    end
  end

endmodule

// ---- hdl/meas_ctrl.sv ----
// Purpose: measurement control and result delivery of a pressure sensor
// Assumes: a slave front end decodes commands and read headers
// Notes: scl and the address strap are pins, synchronised before use
//
// How it works
// R1: strap picks slave address 0x21, 0x22 or 0x23
// R2: alert low while unread result exists
// R3: pressure readout returns alert high
// R4: alert low after reset until measurement command
// R5: continuous mode new result every 0.5 ms
// R6: continuous results land in readable result buffer
// R7: host must not read faster than 0.5 ms
// R8: triggered mode runs one measurement then idles
// R9: busy trigger refuses header or stretches clock
// R10: triggered result ready about 45 ms later
// R11: average-till-read accumulates samples since readout
// R12: first 25 ms report arithmetic mean
// R13: after 25 ms exponential smoothing, factor 0.05
// R14: two temperature compensation modes selectable
// R15: host should pick mass-flow compensation for flow
// R16: four continuous start commands choose mode
// R17: stop command idles, accepts commands after 500 us
// R18: four triggered commands, with or without stretching
// R19: 16-bit commands, words each followed by checksum
// R20: strap sampled once after reset, then held
// R21: new averaging window clears sum and count

`timescale 1ns/1ns
module meas_ctrl
  import meas_ctrl_pkg::*;
#(
  parameter int UPDATE_CYC_P = UPDATE_CYC,
  parameter int TRIG_CYC_P = TRIG_CYC,
  parameter int AVG_WIN_CYC_P = AVG_WIN_CYC,
  parameter int STOP_CYC_P = STOP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic soft_reset_i,
  input wire logic [1:0] addr_strap_i,
  output logic [6:0] slave_addr_o,
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_i,
  output logic cmd_refused_o,
  input wire logic rd_hdr_i,
  output logic rd_ack_o,
  output logic rd_nack_o,
  input wire logic rd_stop_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic word_valid_o,
  input wire logic word_ready_i,
  output logic [15:0] word_data_o,
  output logic [7:0] word_crc_o,
  output logic word_press_o,
  input wire logic [15:0] press_raw_i,
  input wire logic [15:0] temp_raw_i,
  output logic heater_on_o,
  output logic comp_mass_o,
  output logic new_data_alert_n_o
);

  logic scl_s1, scl_s2, scl_d;
  logic [1:0] strap_s1, strap_s2, strap_cnt, next_strap_cnt;
  logic strap_done, next_strap_done;
  logic [6:0] slave_addr, next_slave_addr;
  mode_state_e state, next_state;
  logic [TMR_W-1:0] tmr, next_tmr, win_tmr, next_win;
  logic trig_str, next_str, comp_mass, next_mass, avg_on, next_avg;
  logic meas_cmd, sample_tick, pop_press, push_ok, buf_ready;
  logic signed [15:0] x;
  logic [15:0] press_res, next_press, temp_res, next_temp, cur_word;
  logic has_data, next_has, alert_flag, next_alert;
  logic signed [31:0] avg_sum, next_sum, sum1, exp_s, next_exp_s;
  logic [31:0] exp_new;
  logic [7:0] avg_n, next_n, n1;
  logic exp_phase, next_exp_ph;
  logic signed [32:0] exp_diff;
  logic signed [49:0] exp_prod;
  logic rd_active, next_rd_act, stretch_wait, next_swait;
  logic hold_scl, next_hold;
  logic [1:0] rd_idx, next_idx;
  logic [WORD_W-1:0] buf_out;
  logic started;
  logic [TMR_W-1:0] trig_age;

  assign x = press_raw_i;
  assign slave_addr_o = slave_addr;
  assign heater_on_o = (state == ST_CONT) || (state == ST_TRIG); // R8
  assign comp_mass_o = comp_mass; // R14
  assign new_data_alert_n_o = !alert_flag; // R2
  assign scl_o = 1'b0;
  assign scl_oe_o = hold_scl; // R9

  // pins: first stage feeds only the second
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      strap_s1 <= STRAP_GND;
      strap_s2 <= STRAP_GND;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      strap_s1 <= addr_strap_i;
      strap_s2 <= strap_s1;
    end
  end

  // strap is caught once the synchroniser has settled
  always_comb begin
    next_strap_cnt = strap_cnt;
    next_strap_done = strap_done;
    next_slave_addr = slave_addr;
    if (!strap_done) begin
      if (strap_cnt == STRAP_SETTLE) begin
        next_strap_done = 1'b1; // R20
        case (strap_s2) // R1
          STRAP_R1K2: next_slave_addr = ADDR_R1K2;
          STRAP_R2K7: next_slave_addr = ADDR_R2K7;
          default: next_slave_addr = ADDR_GND;
        endcase
      end else begin
        next_strap_cnt = strap_cnt + 2'h1;
      end
    end
    if (soft_reset_i) begin
      next_strap_cnt = 2'h0;
      next_strap_done = 1'b0; // R20
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      slave_addr <= ADDR_GND;
    end else begin
      strap_cnt <= next_strap_cnt;
      strap_done <= next_strap_done;
      slave_addr <= next_slave_addr;
    end
  end

  assign sample_tick = !soft_reset_i &&
    ((state == ST_CONT && tmr == TMR_W'(UPDATE_CYC_P - 1)) || // R5 R6
     (state == ST_TRIG && tmr == TMR_W'(TRIG_CYC_P - 1))); // R10

  always_comb begin
    next_state = state;
    next_tmr = tmr + 1'b1;
    next_str = trig_str;
    next_mass = comp_mass;
    next_avg = avg_on;
    meas_cmd = 1'b0;
    cmd_refused_o = 1'b0;
    case (state)
      ST_IDLE: begin
        next_tmr = '0;
        if (cmd_valid_i) begin
          case (cmd_i) // R16 R18 R19
            CMD_CONT_MF_AVG, CMD_CONT_MF, CMD_CONT_DP_AVG, CMD_CONT_DP: begin
              next_state = ST_CONT;
              meas_cmd = 1'b1;
              next_mass = (cmd_i == CMD_CONT_MF_AVG) || (cmd_i == CMD_CONT_MF);
              next_avg = (cmd_i == CMD_CONT_MF_AVG) ||
                         (cmd_i == CMD_CONT_DP_AVG); // R11
            end
            CMD_TRIG_MF, CMD_TRIG_MF_STR, CMD_TRIG_DP, CMD_TRIG_DP_STR: begin
              next_state = ST_TRIG; // R8
              meas_cmd = 1'b1;
              next_mass = (cmd_i == CMD_TRIG_MF) || (cmd_i == CMD_TRIG_MF_STR);
              next_str = (cmd_i == CMD_TRIG_MF_STR) ||
                         (cmd_i == CMD_TRIG_DP_STR);
              next_avg = 1'b0;
            end
            CMD_STOP: next_state = ST_STOP;
            default: cmd_refused_o = 1'b1;
          endcase
        end
      end
      ST_CONT: begin
        if (tmr == TMR_W'(UPDATE_CYC_P - 1)) begin
          next_tmr = '0;
        end
        if (cmd_valid_i && cmd_i == CMD_STOP) begin
          next_state = ST_STOP; // R17
          next_tmr = '0;
        end else if (cmd_valid_i) begin
          cmd_refused_o = 1'b1;
        end
      end
      ST_TRIG: begin
        cmd_refused_o = cmd_valid_i;
        if (tmr == TMR_W'(TRIG_CYC_P - 1)) begin
          next_state = ST_IDLE; // R8 R10
          next_tmr = '0;
        end
      end
      ST_STOP: begin
        cmd_refused_o = cmd_valid_i; // R17
        if (tmr == TMR_W'(STOP_CYC_P - 1)) begin
          next_state = ST_IDLE;
          next_tmr = '0;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_tmr = '0;
      end
    endcase
    if (soft_reset_i) begin
      next_state = ST_IDLE;
      next_tmr = '0;
      next_str = 1'b0;
      next_mass = 1'b0;
      next_avg = 1'b0;
      meas_cmd = 1'b0;
      cmd_refused_o = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      tmr <= '0;
      trig_str <= 1'b0;
      comp_mass <= 1'b0;
      avg_on <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      trig_str <= next_str;
      comp_mass <= next_mass;
      avg_on <= next_avg;
    end
  end

  assign pop_press = word_valid_o && word_ready_i && word_press_o;

  // plain divide: one result per update period, speed is no concern
  always_comb begin
    next_press = press_res;
    next_temp = temp_res;
    next_has = has_data;
    next_alert = alert_flag;
    next_sum = avg_sum;
    next_n = avg_n;
    next_win = win_tmr;
    next_exp_ph = exp_phase;
    next_exp_s = exp_s;
    if (avg_on && !exp_phase && state == ST_CONT) begin
      if (win_tmr == TMR_W'(AVG_WIN_CYC_P - 1)) begin
        next_exp_ph = 1'b1; // R13
        next_exp_s = {press_res, 16'h0000};
      end else begin
        next_win = win_tmr + 1'b1;
      end
    end
    if (pop_press || meas_cmd) begin
      next_alert = 1'b0; // R3
      next_sum = '0; // R21
      next_n = 8'h00;
      next_win = '0;
      next_exp_ph = 1'b0;
    end
    if (meas_cmd) begin
      next_has = 1'b0;
    end
    sum1 = next_sum + 32'(x);
    n1 = next_n + 8'h01;
    exp_diff = $signed({x[15], x, 16'h0000}) -
               $signed({next_exp_s[31], next_exp_s});
    exp_prod = exp_diff * $signed({1'b0, ALPHA_Q16});
    exp_new = next_exp_s + exp_prod[47:16];
    if (sample_tick) begin
      next_temp = temp_raw_i;
      next_has = 1'b1; // R6
      next_alert = 1'b1; // R2 R5
      if (!avg_on || state == ST_TRIG) begin
        next_press = press_raw_i;
      end else if (!next_exp_ph) begin
        next_sum = sum1; // R11
        next_n = n1;
        next_press = 16'(sum1 / $signed(32'(n1))); // R12
      end else begin
        next_exp_s = exp_new; // R13
        next_press = exp_new[31:16];
      end
    end
    if (soft_reset_i) begin
      next_alert = 1'b1; // R4
      next_has = 1'b0;
      next_sum = '0;
      next_n = 8'h00;
      next_win = '0;
      next_exp_ph = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      press_res <= 16'h0000;
      temp_res <= 16'h0000;
      has_data <= 1'b0;
      alert_flag <= 1'b1; // R4
      avg_sum <= '0;
      avg_n <= 8'h00;
      win_tmr <= '0;
      exp_phase <= 1'b0;
      exp_s <= '0;
    end else begin
      press_res <= next_press;
      temp_res <= next_temp;
      has_data <= next_has;
      alert_flag <= next_alert;
      avg_sum <= next_sum;
      avg_n <= next_n;
      win_tmr <= next_win;
      exp_phase <= next_exp_ph;
      exp_s <= next_exp_s;
    end
  end

  assign push_ok = rd_active && buf_ready;

  always_comb begin
    next_rd_act = rd_active;
    next_idx = rd_idx;
    next_swait = stretch_wait;
    next_hold = hold_scl;
    rd_ack_o = 1'b0;
    rd_nack_o = 1'b0;
    if (push_ok) begin
      next_idx = rd_idx + 2'h1;
      if (rd_idx == WORD_SCALE) begin
        next_rd_act = 1'b0;
      end
    end
    if (stretch_wait && scl_d && !scl_s2) begin
      next_hold = 1'b1; // R9
    end
    if (stretch_wait && sample_tick) begin
      next_swait = 1'b0;
      next_hold = 1'b0;
      next_rd_act = 1'b1;
      next_idx = WORD_PRESS;
    end
    if (rd_hdr_i) begin
      // header on the finishing tick is nacked, else the stretch never ends
      if (state == ST_TRIG && trig_str && !sample_tick) begin
        rd_ack_o = 1'b1; // R9
        next_swait = 1'b1;
        next_rd_act = 1'b0;
      end else if (state == ST_TRIG || !has_data) begin
        rd_nack_o = 1'b1; // R9
      end else begin
        rd_ack_o = 1'b1;
        next_rd_act = 1'b1;
        next_idx = WORD_PRESS;
      end
    end
    if (rd_stop_i || soft_reset_i) begin
      next_rd_act = 1'b0;
      next_swait = 1'b0;
      next_hold = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_active <= 1'b0;
      rd_idx <= WORD_PRESS;
      stretch_wait <= 1'b0;
      hold_scl <= 1'b0;
    end else begin
      rd_active <= next_rd_act;
      rd_idx <= next_idx;
      stretch_wait <= next_swait;
      hold_scl <= next_hold;
    end
  end

  always_comb begin
    case (rd_idx) // R19
      WORD_PRESS: cur_word = press_res;
      WORD_TEMP: cur_word = temp_res;
      default: cur_word = SCALE_FACTOR;
    endcase
  end

  pair_buf #(
    .W(WORD_W)
  ) u_buf (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(rd_hdr_i || rd_stop_i || soft_reset_i),
    .in_valid_i(rd_active),
    .in_data_i({rd_idx == WORD_PRESS, cur_word, crc8(cur_word)}),
    .in_ready_o(buf_ready),
    .out_valid_o(word_valid_o),
    .out_data_o(buf_out),
    .out_ready_i(word_ready_i)
  );

  assign word_press_o = buf_out[24];
  assign word_data_o = buf_out[23:8];
  assign word_crc_o = buf_out[7:0];

  // helper state read only by the checks below
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      started <= 1'b0;
      trig_age <= '0;
    end else begin
      started <= soft_reset_i ? 1'b0 : (started || meas_cmd);
      trig_age <= (state == ST_TRIG) ? trig_age + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence stop_taken;
    state == ST_CONT && cmd_valid_i && cmd_i == CMD_STOP && !soft_reset_i;
  endsequence
  sequence stop_held;
    (state == ST_STOP && !heater_on_o) [*2];
  endsequence

  addr_map_a: assert property ($rose(strap_done) && // R1
    $past(strap_s2) == STRAP_R2K7 |-> slave_addr_o == ADDR_R2K7)
    else $error("strap decode gave wrong address");
  addr_hold_a: assert property (strap_done && !soft_reset_i |=> // R20
    $stable(slave_addr_o)) else $error("address moved after capture");
  alert_boot_a: assert property (!started |-> // R4
    !new_data_alert_n_o) else $error("alert high before first command");
  alert_new_a: assert property (sample_tick |=> // R5
    !new_data_alert_n_o) else $error("new result did not pull alert");
  alert_read_a: assert property (pop_press && !sample_tick && // R3
    !soft_reset_i |=> new_data_alert_n_o)
    else $error("pressure read left alert low");
  trig_nack_a: assert property (rd_hdr_i && state == ST_TRIG && // R9
    !trig_str |-> rd_nack_o && !rd_ack_o)
    else $error("header acked during busy trigger");
  scl_hold_a: assert property (scl_oe_o |-> // R9
    state == ST_TRIG || $past(state) == ST_TRIG)
    else $error("clock held outside a trigger");
  trig_time_a: assert property ($fell(state == ST_TRIG) && // R10
    !$past(soft_reset_i) |-> trig_age == TMR_W'(TRIG_CYC_P) && has_data)
    else $error("trigger length wrong");
  stop_wait_a: assert property (stop_taken |=> stop_held) // R17
    else $error("stop did not idle the heater");
  avg_clear_a: assert property (pop_press && !sample_tick && // R21
    !soft_reset_i |=> avg_n == 8'h00) else $error("window not cleared");
  avg_switch_a: assert property ($rose(exp_phase) && // R13
    !$past(sample_tick) |-> exp_s[31:16] == press_res)
    else $error("smoothing not seeded by mean");

endmodule

// ---- tb/host_model.sv ----
// Purpose: host side of the link, clock line and word sink
// Assumes: open-drain clock line with pull-up
// Notes: clock stands high outside frames
`timescale 1ns/1ns
module host_model (
  input wire logic ref_clk_i,
  input wire logic frame_i,
  input wire logic stall_i,
  input wire logic scl_oe_i,
  output logic scl_line_o,
  output logic word_ready_o
);
  logic drv;
  initial begin
    drv = 1'b1;
    #3;
    forever begin
      #40;
      // a held-low line makes the host wait
      if (scl_line_o | ~frame_i) begin
        drv = frame_i ? ~drv : 1'b1;
      end
    end
  end
  assign scl_line_o = drv & ~scl_oe_i;
  always @(posedge ref_clk_i) begin
    word_ready_o <= ~stall_i;
  end
endmodule

// ---- tb/pressure_sensor_meas_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the measurement block
// Assumes: shortened timing counts, host model on the link side
// Notes: strap decode and command table first, reads and averaging by hand
`timescale 1ns/1ns
module pressure_sensor_meas_ctrl_tb_top
  import meas_ctrl_pkg::*;
;
  localparam int UPD = 20;
  localparam int TRG = 200;
  localparam int AVG = 100;
  localparam int STP = 10;
  logic ref_clk, rst_n, soft_reset, cmd_valid, rd_hdr, rd_stop;
  logic frame, stall, scl_line, rdy, refused, ack, nack, scl_oe;
  logic wv, wp, heater, comp, alert, scl_drv;
  logic [1:0] strap;
  logic [15:0] cmd, press, temp, wd;
  logic [7:0] wc;
  logic [6:0] slave_addr;
  logic [24:0] got [3];
  int miscompares, checks_done;
  logic [6:0] addr_tbl [3] = '{7'h21, 7'h22, 7'h23};
  // bits: continuous, mass flow, stretching, code
  logic [18:0] rows [8] = '{
    {3'b110, CMD_CONT_MF_AVG}, {3'b110, CMD_CONT_MF},
    {3'b100, CMD_CONT_DP_AVG}, {3'b100, CMD_CONT_DP},
    {3'b010, CMD_TRIG_MF}, {3'b011, CMD_TRIG_MF_STR},
    {3'b000, CMD_TRIG_DP}, {3'b001, CMD_TRIG_DP_STR}};

  meas_ctrl #(.UPDATE_CYC_P(UPD), .TRIG_CYC_P(TRG), .AVG_WIN_CYC_P(AVG),
    .STOP_CYC_P(STP)) dut (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .soft_reset_i(soft_reset),
    .addr_strap_i(strap), .slave_addr_o(slave_addr),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_refused_o(refused),
    .rd_hdr_i(rd_hdr), .rd_ack_o(ack), .rd_nack_o(nack),
    .rd_stop_i(rd_stop), .scl_i(scl_line), .scl_o(scl_drv),
    .scl_oe_o(scl_oe),
    .word_valid_o(wv), .word_ready_i(rdy), .word_data_o(wd),
    .word_crc_o(wc), .word_press_o(wp), .press_raw_i(press),
    .temp_raw_i(temp), .heater_on_o(heater), .comp_mass_o(comp),
    .new_data_alert_n_o(alert));

  host_model host (.ref_clk_i(ref_clk), .frame_i(frame), .stall_i(stall),
    .scl_oe_i(scl_oe), .scl_line_o(scl_line), .word_ready_o(rdy));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] crc_of(input logic [15:0] v);
    logic [7:0] r;
    r = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      r = (r[7] ^ v[i]) ? {r[6:0], 1'b0} ^ CRC_POLY : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic pick(input int s);
    return s == 0 ? alert : s == 1 ? wv : scl_oe;
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // bounded wait; running out ends the run
  task wt(input int s, input logic v, input int n);
    int i;
    for (i = 0; i < n && pick(s) !== v; i++) begin
      step(1);
    end
    if (pick(s) !== v) begin
      chk(pick(s), v);
      end_of_test();
    end
  endtask

  task send(input logic [15:0] code, input logic no);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= code;
    #1;
    chk(refused, no);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask

  task rd(input logic a);
    @(posedge ref_clk);
    rd_hdr <= 1'b1;
    #1;
    chk({ack, nack}, {a, ~a});
    @(posedge ref_clk);
    rd_hdr <= 1'b0;
    #1;
  endtask

  task getw(output logic [24:0] w);
    int i;
    for (i = 0; i < 400 && !(wv === 1'b1 && rdy === 1'b1); i++) begin
      step(1);
    end
    w = {wp, wd, wc};
    if (!(wv === 1'b1 && rdy === 1'b1)) begin
      chk({wv, rdy}, 2'b11);
      end_of_test();
    end else begin
      step(1);
    end
  endtask

  initial begin
    {rst_n, soft_reset, cmd_valid, rd_hdr, rd_stop, frame, stall} = '0;
    strap = 2'h0;
    cmd = 16'h0000;
    press = 16'h1000;
    temp = 16'h0ABC;
    miscompares = 0;
    checks_done = 0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    step(1);
    chk({alert, scl_oe, heater}, 3'b000);
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      strap <= 2'(k);
      @(posedge ref_clk);
      soft_reset <= 1'b1;
      @(posedge ref_clk);
      soft_reset <= 1'b0;
      step(6);
      chk(slave_addr, addr_tbl[k]);
      chk(alert, 1'b0);
      @(posedge ref_clk);
      strap <= 2'(k + 1);
      step(6);
      chk(slave_addr, addr_tbl[k]);
    end
    send(16'h1234, 1'b1);
    foreach (rows[k]) begin
      send(rows[k][15:0], 1'b0);
      chk({heater, comp, alert}, {1'b1, rows[k][17], 1'b1});
      if (rows[k][18]) begin
        send(CMD_TRIG_MF, 1'b1);
        step(UPD - 4);
        chk(alert, 1'b1);
        wt(0, 1'b0, 6);
        send(CMD_STOP, 1'b0);
        chk(heater, 1'b0);
        send(rows[k][15:0], 1'b1);
        step(STP);
      end else begin
        rd(rows[k][16]);
        if (rows[k][16]) begin
          @(posedge ref_clk);
          frame <= 1'b1;
          wt(2, 1'b1, 60);
          step(TRG - 60);
          chk({scl_oe, scl_drv}, 2'b10);
          wt(2, 1'b0, 80);
          @(posedge ref_clk);
          frame <= 1'b0;
        end else begin
          send(rows[k][15:0], 1'b1);
          step(TRG - 12);
          chk(alert, 1'b1);
          wt(0, 1'b0, 20);
        end
        step(2);
        chk(heater, 1'b0);
      end
    end
    // mass-flow compensation for a flow read
    @(posedge ref_clk);
    stall <= 1'b1;
    send(CMD_CONT_MF, 1'b0);
    wt(0, 1'b0, UPD + 4);
    rd(1'b1);
    step(4);
    chk({wv, wp, alert}, 3'b110);
    @(posedge ref_clk);
    stall <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      getw(got[k]);
    end
    chk(alert, 1'b1);
    chk(got[0], {1'b1, 16'h1000, crc_of(16'h1000)});
    chk(got[1], {1'b0, 16'h0ABC, crc_of(16'h0ABC)});
    chk(got[2], {1'b0, SCALE_FACTOR, crc_of(SCALE_FACTOR)});
    wt(0, 1'b0, UPD + 4);
    @(posedge ref_clk);
    stall <= 1'b1;
    rd(1'b1);
    step(3);
    @(posedge ref_clk);
    rd_stop <= 1'b1;
    @(posedge ref_clk);
    rd_stop <= 1'b0;
    step(2);
    chk({wv, alert}, 2'b00);
    @(posedge ref_clk);
    stall <= 1'b0;
    send(CMD_STOP, 1'b0);
    step(STP);
    send(CMD_CONT_DP_AVG, 1'b0);
    wt(0, 1'b0, UPD + 4);
    @(posedge ref_clk);
    press <= 16'h2000;
    step(2 * UPD);
    rd(1'b1);
    getw(got[0]);
    // mean of 0x1000, 0x2000, 0x2000, truncated
    chk(got[0][24:8], {1'b1, 16'h1AAA});
    @(posedge ref_clk);
    press <= 16'h2000;
    wt(0, 1'b0, UPD + 4);
    step(2 * UPD);
    rd(1'b1);
    getw(got[0]);
    chk(got[0][24:8], {1'b1, 16'h2000});
    step(7 * UPD);
    @(posedge ref_clk);
    press <= 16'h3000;
    step(56);
    rd(1'b1);
    getw(got[0]);
    chk(got[0][23:8] > 16'h2000 && got[0][23:8] < 16'h2333, 1'b1);
    @(posedge ref_clk);
    soft_reset <= 1'b1;
    @(posedge ref_clk);
    soft_reset <= 1'b0;
    step(1);
    chk({alert, heater, wv}, 3'b000);
    send(CMD_STOP, 1'b0);
    send(CMD_CONT_MF, 1'b1);
    step(STP);
    chk({alert, slave_addr}, {1'b0, 7'h21});
    end_of_test();
  end
endmodule
